// ==== interrupt_status_collector_bench.sv ====
// self-checking bench for the interrupt status collector
// assumes isc_host_model drives the register strobes
`timescale 1ns/1ps
`include "isc_cfg.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
module interrupt_status_collector_bench;
    import isc_pkg::*;
    logic core_clk = 1'b0, reset_n = 1'b0, drop_count_inc = 1'b0, timer_tick = 1'b0;
    logic phy_event_pending = 1'b0, reg_wr, reg_rd, master_irq, power_irq, wake_request;
    logic [21:0] ev = '0;
    logic [15:0] timer_count = 16'h0;
    isc_word_t   irq_enable_mask = 32'hFFFF_FFFF, drop_count = 32'h0, q, reg_wdata, reg_rdata;
    isc_addr_t   reg_addr;
    int          n_errors = 0, checks = 0, cycles = 0;
    // one event condition per row, two of them paired inputs; two rows show a half condition setting nothing
    logic [21:0] row_ev [0:21] = '{22'h1, 22'h2, 22'h4, 22'h8, 22'h10, 22'h20, 22'h40,
        22'h80, 22'h100, 22'h200, 22'h400, 22'h800, 22'h1000, 22'h2000, 22'h4000,
        22'h8000, 22'h30000, 22'h10000, 22'h40000, 22'h180000, 22'h80000, 22'h200000};
    isc_word_t   row_st [0:21] = '{32'h1, 32'h2, 32'h4, 32'h8, 32'h10, 32'h40, 32'h80,
        32'h100, 32'h200, 32'h400, 32'h2000, 32'h4000, 32'h8000, 32'h10000, 32'h20000,
        32'h100000, 32'h200000, 32'h0, 32'h1000000, 32'h2000000, 32'h0, 32'h8000_0000};
    always #4 core_clk = ~core_clk;
    isc_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    isc_collector uut (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .irq_enable_mask, .soft_irq_enable(ev[21]), .tx_stop_request(ev[20]),
        .tx_halted(ev[19]), .rx_halted(ev[18]), .drop_count_inc, .drop_count,
        .tx_buffer_loaded(ev[16]), .notify_on_completion(ev[17]),
        .rx_dma_count_done(ev[15]), .timer_tick, .timer_count, .phy_event_pending,
        .power_event(ev[14]), .tx_stat_overflow(ev[13]), .rx_oversize(ev[12]),
        .rx_error(ev[11]), .tx_error(ev[10]), .tx_fifo_write_full(ev[9]),
        .tx_space_above_level(ev[8]), .tx_stat_full(ev[7]), .tx_stat_level(ev[6]),
        .rx_stat_full(ev[4]), .rx_stat_level(ev[3]), .rx_frame_dropped(ev[5]),
        .pin_events(ev[2:0]), .master_irq, .power_irq, .wake_request);
    task automatic final_report();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pulse_ev(input logic [21:0] v);
        @(negedge core_clk) ev = v;
        @(negedge core_clk) ev = '0;
    endtask
    task automatic see(input isc_word_t e);
        host.rd(`ISC_OFS_STATUS, q);
        `CHK("status", e, q)
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        see(`ISC_STATUS_RESET);
        for (int i = 0; i < 22; i++) begin
            pulse_ev(row_ev[i]);
            see(row_st[i]);
            `CHK("master", |row_st[i], master_irq)
            `CHK("power", row_st[i][17], power_irq)
            host.wr(`ISC_OFS_STATUS, row_st[i]);
            see(32'h0);
        end
        irq_enable_mask = 32'h0;
        pulse_ev(22'h800);
        `CHK("master", 1'b0, master_irq)
        host.wr(`ISC_OFS_STATUS, 32'hFFFF_BFFF);
        see(32'h4000);
        irq_enable_mask = 32'h4000;
        @(negedge core_clk);
        `CHK("master", 1'b1, master_irq)
        host.wr(`ISC_OFS_STATUS, 32'h4000);
        ev = 22'h800;
        host.wr(`ISC_OFS_STATUS, 32'h4000);
        ev = '0;
        see(32'h4000);
        host.wr(`ISC_OFS_STATUS, 32'h4000);
        drop_count = 32'h7FFF_FFFE;
        drop_count_inc = 1'b1;
        timer_count = 16'h0001;
        timer_tick = 1'b1;
        @(negedge core_clk);
        drop_count = `ISC_DROP_HALF_PREV;
        timer_count = `ISC_TIMER_ZERO;
        @(negedge core_clk);
        drop_count_inc = 1'b0;
        timer_tick = 1'b0;
        see(32'h0088_0000);
        phy_event_pending = 1'b1;
        host.wr(`ISC_OFS_STATUS, 32'hFFFF_FFFF);
        see(32'h0004_0000);
        phy_event_pending = 1'b0;
        pulse_ev(22'h4000);
        `CHK("wake", 1'b0, wake_request)
        host.wr(`ISC_OFS_BYTE_TEST, 32'h0);
        `CHK("wake", 1'b1, wake_request)
        @(negedge core_clk);
        `CHK("wake", 1'b0, wake_request)
        see(32'h0002_0000);
        host.rd(8'h70, q);
        `CHK("unmapped", 32'h0, q)
        final_report();
    end
endmodule

// ==== isc_cfg.svh ====
// offsets, bit positions and reset values for the interrupt status collector
// assumes inclusion once per compilation unit through the guard below
`ifndef ISC_CFG_SVH
`define ISC_CFG_SVH
`define ISC_OFS_STATUS     8'h58
`define ISC_OFS_BYTE_TEST  8'h64
`define ISC_STATUS_RESET   32'h0000_0000
`define ISC_WC_MASK        32'h83BB_E7DF
`define ISC_BIT_SOFT       31
`define ISC_BIT_TX_HALT    25
`define ISC_BIT_RX_HALT    24
`define ISC_BIT_DROP_HALF  23
`define ISC_BIT_TX_DONE    21
`define ISC_BIT_RX_DMA     20
`define ISC_BIT_TIMER      19
`define ISC_BIT_PHY        18
`define ISC_BIT_POWER      17
`define ISC_BIT_TX_SOVF    16
`define ISC_BIT_RX_WDOG    15
`define ISC_BIT_RX_ERR     14
`define ISC_BIT_TX_ERR     13
`define ISC_BIT_TX_OVRUN   10
`define ISC_BIT_TX_AVAIL   9
`define ISC_BIT_TX_SFULL   8
`define ISC_BIT_TX_SLVL    7
`define ISC_BIT_RX_DROP    6
`define ISC_BIT_RX_SFULL   4
`define ISC_BIT_RX_SLVL    3
`define ISC_BIT_PIN_LO     0
`define ISC_DROP_HALF_PREV 32'h7FFF_FFFF
`define ISC_DROP_HALF_NEXT 32'h8000_0000
`define ISC_TIMER_TOP      16'hFFFF
`define ISC_TIMER_ZERO     16'h0000
`define ISC_PIN_COUNT      3
`define ISC_TIMER_WIDTH    16
`endif

// ==== isc_collector.sv ====
// interrupt status collector: sticky event flags, write-one-to-clear access
// assumes event inputs are single-cycle pulses or levels synchronous to core_clk
`timescale 1ns/1ps
`include "isc_cfg.svh"

// Behaviour
// - writing one clears a flag
// - soft flag set while soft enable high
// - tx halted flag on stop request and halt
// - rx halted flag on receiver halt
// - drop count crossing midpoint sets flag
// - tx buffer done on notify buffer loaded
// - rx dma count moved sets flag
// - timer wrap zero to FFFFh sets flag
// - phy flag read-only, mirrors pending event
// - power flag latches, clears by one write
// - only byte test write wakes device
// - power flag bypasses deassertion interval
// - tx status overflow sets flag
// - oversize received packet sets watchdog flag
// - receiver error sets flag
// - transmitter error sets flag
// - write to full tx fifo sets flag
// - tx space above threshold sets flag
// - tx and rx status full flags
// - tx and rx status level flags
// - dropped frame sets flag
// - three pin event flags, write-one clear
// - flags latch regardless of mask
// - master indication when enabled flag set
module isc_collector #(
    parameter int PIN_COUNT   = `ISC_PIN_COUNT,
    parameter int TIMER_WIDTH = `ISC_TIMER_WIDTH
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire isc_pkg::isc_addr_t reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire isc_pkg::isc_word_t reg_wdata,
    output isc_pkg::isc_word_t    reg_rdata,
    input  wire isc_pkg::isc_word_t irq_enable_mask,
    input  wire logic             soft_irq_enable,
    input  wire logic             tx_stop_request,
    input  wire logic             tx_halted,
    input  wire logic             rx_halted,
    input  wire logic             drop_count_inc,
    input  wire isc_pkg::isc_word_t drop_count,
    input  wire logic             tx_buffer_loaded,
    input  wire logic             notify_on_completion,
    input  wire logic             rx_dma_count_done,
    input  wire logic             timer_tick,
    input  wire logic [TIMER_WIDTH-1:0] timer_count,
    input  wire logic             phy_event_pending,
    input  wire logic             power_event,
    input  wire logic             tx_stat_overflow,
    input  wire logic             rx_oversize,
    input  wire logic             rx_error,
    input  wire logic             tx_error,
    input  wire logic             tx_fifo_write_full,
    input  wire logic             tx_space_above_level,
    input  wire logic             tx_stat_full,
    input  wire logic             tx_stat_level,
    input  wire logic             rx_stat_full,
    input  wire logic             rx_stat_level,
    input  wire logic             rx_frame_dropped,
    input  wire logic [PIN_COUNT-1:0] pin_events,
    output logic                  master_irq,
    output logic                  power_irq,
    output logic                  wake_request
);
    import isc_pkg::*;

    // the flag map has fixed room: three pin events and a 16-bit timer
    if (PIN_COUNT != `ISC_PIN_COUNT) begin : g_pin_check
        $error("pin event count does not fit the flag map");
    end
    if (TIMER_WIDTH != `ISC_TIMER_WIDTH) begin : g_timer_check
        $error("timer width does not match the wrap value");
    end

    isc_word_t irq_status_reg;
    isc_word_t next_status;
    isc_word_t set_vec;
    isc_word_t clr_vec;
    logic      next_master;
    logic      next_power;
    logic      next_wake;
    logic [31:0] next_rdata;

    // levels re-set every cycle they stand, so a clear sticks only once the source drops
    always_comb begin
        set_vec = '0;
        set_vec[`ISC_BIT_SOFT]      = soft_irq_enable;
        set_vec[`ISC_BIT_TX_HALT]   = tx_stop_request & tx_halted;
        set_vec[`ISC_BIT_RX_HALT]   = rx_halted;
        set_vec[`ISC_BIT_DROP_HALF] = drop_count_inc
                                      & (drop_count == `ISC_DROP_HALF_PREV);
        set_vec[`ISC_BIT_TX_DONE]   = tx_buffer_loaded & notify_on_completion;
        set_vec[`ISC_BIT_RX_DMA]    = rx_dma_count_done;
        set_vec[`ISC_BIT_TIMER]     = timer_tick
                                      & (timer_count == `ISC_TIMER_ZERO);
        set_vec[`ISC_BIT_POWER]     = power_event;
        set_vec[`ISC_BIT_TX_SOVF]   = tx_stat_overflow;
        set_vec[`ISC_BIT_RX_WDOG]   = rx_oversize;
        set_vec[`ISC_BIT_RX_ERR]    = rx_error;
        set_vec[`ISC_BIT_TX_ERR]    = tx_error;
        set_vec[`ISC_BIT_TX_OVRUN]  = tx_fifo_write_full;
        set_vec[`ISC_BIT_TX_AVAIL]  = tx_space_above_level;
        set_vec[`ISC_BIT_TX_SFULL]  = tx_stat_full;
        set_vec[`ISC_BIT_RX_SFULL]  = rx_stat_full;
        set_vec[`ISC_BIT_TX_SLVL]   = tx_stat_level;
        set_vec[`ISC_BIT_RX_SLVL]   = rx_stat_level;
        set_vec[`ISC_BIT_RX_DROP]   = rx_frame_dropped;
        set_vec[`ISC_BIT_PIN_LO +: PIN_COUNT] = pin_events;
    end

    // reserved and read-only bits never see a clear
    assign clr_vec = (reg_wr && reg_addr == `ISC_OFS_STATUS)
                   ? (reg_wdata & `ISC_WC_MASK) : '0;

    always_comb begin
        // set wins over a clear in the same cycle
        next_status = ((irq_status_reg & ~clr_vec) | set_vec) & `ISC_WC_MASK;
        next_status[`ISC_BIT_PHY] = phy_event_pending;
        // mask gates only the indication, never the latching
        next_master = |(next_status & irq_enable_mask);
        next_power  = next_status[`ISC_BIT_POWER] & irq_enable_mask[`ISC_BIT_POWER];
        // wake is a one-cycle request; power events alone never raise it
        next_wake   = reg_wr && reg_addr == `ISC_OFS_BYTE_TEST;
        // read data holds between reads so a slow host can sample late
        next_rdata  = reg_rdata;
        if (reg_rd) begin
            next_rdata = (reg_addr == `ISC_OFS_STATUS) ? irq_status_reg : '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            irq_status_reg <= `ISC_STATUS_RESET;
            master_irq     <= 1'b0;
            power_irq      <= 1'b0;
            wake_request   <= 1'b0;
            reg_rdata      <= '0;
        end else begin
            irq_status_reg <= next_status;
            master_irq     <= next_master;
            power_irq      <= next_power;
            wake_request   <= next_wake;
            reg_rdata      <= next_rdata;
        end
    end

    chk_clear_by_one: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `ISC_OFS_STATUS && reg_wdata[`ISC_BIT_RX_ERR] && !rx_error)
        |=> !irq_status_reg[`ISC_BIT_RX_ERR])
        else $error("written one did not clear flag");
    chk_soft_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        soft_irq_enable |=> irq_status_reg[`ISC_BIT_SOFT])
        else $error("soft flag not set");
    chk_tx_halt: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tx_halted && !tx_stop_request && !irq_status_reg[`ISC_BIT_TX_HALT])
        |=> !irq_status_reg[`ISC_BIT_TX_HALT])
        else $error("tx halt flag without stop request");
    chk_drop_half: assert property (@(posedge core_clk) disable iff (!reset_n)
        (drop_count_inc && drop_count == `ISC_DROP_HALF_PREV)
        |=> irq_status_reg[`ISC_BIT_DROP_HALF])
        else $error("midpoint crossing missed");
    chk_timer_wrap: assert property (@(posedge core_clk) disable iff (!reset_n)
        (timer_tick && timer_count == `ISC_TIMER_ZERO) |=> irq_status_reg[`ISC_BIT_TIMER])
        else $error("timer wrap missed");
    chk_phy_mirror: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_status_reg[`ISC_BIT_PHY] == $past(phy_event_pending))
        else $error("phy flag not mirroring");
    chk_power_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
        power_event |=> irq_status_reg[`ISC_BIT_POWER] ##1 power_irq
                         == irq_enable_mask[`ISC_BIT_POWER] || !irq_status_reg[`ISC_BIT_POWER]
                         || $changed(irq_enable_mask))
        else $error("power flag not latched");
    chk_wake_src: assert property (@(posedge core_clk) disable iff (!reset_n)
        wake_request |-> $past(reg_wr) && $past(reg_addr) == `ISC_OFS_BYTE_TEST)
        else $error("wake without byte test write");
    chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        (irq_status_reg & ~(`ISC_WC_MASK | (32'h1 << `ISC_BIT_PHY))) == '0)
        else $error("reserved bit set");
    chk_master_ind: assert property (@(posedge core_clk) disable iff (!reset_n)
        master_irq == |(irq_status_reg & $past(irq_enable_mask)))
        else $error("master indication wrong");

    // event sources each latch their own flag
    chk_rx_halt: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_halted |=> irq_status_reg[`ISC_BIT_RX_HALT])
        else $error("rx halt flag missed");
    chk_rx_dma: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_dma_count_done |=> irq_status_reg[`ISC_BIT_RX_DMA])
        else $error("rx dma flag missed");
    chk_tx_sovf: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_stat_overflow |=> irq_status_reg[`ISC_BIT_TX_SOVF])
        else $error("tx status overflow flag missed");
    chk_rx_wdog: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_oversize |=> irq_status_reg[`ISC_BIT_RX_WDOG])
        else $error("rx watchdog flag missed");
    chk_rx_err: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_error |=> irq_status_reg[`ISC_BIT_RX_ERR])
        else $error("rx error flag missed");
    chk_tx_err: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_error |=> irq_status_reg[`ISC_BIT_TX_ERR])
        else $error("tx error flag missed");
    chk_tx_overrun: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_fifo_write_full |=> irq_status_reg[`ISC_BIT_TX_OVRUN])
        else $error("tx overrun flag missed");
    chk_tx_avail: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_space_above_level |=> irq_status_reg[`ISC_BIT_TX_AVAIL])
        else $error("tx space flag missed");
    chk_tx_sfull: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_stat_full |=> irq_status_reg[`ISC_BIT_TX_SFULL])
        else $error("tx status full flag missed");
    chk_rx_sfull: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_stat_full |=> irq_status_reg[`ISC_BIT_RX_SFULL])
        else $error("rx status full flag missed");
    chk_tx_slvl: assert property (@(posedge core_clk) disable iff (!reset_n)
        tx_stat_level |=> irq_status_reg[`ISC_BIT_TX_SLVL])
        else $error("tx status level flag missed");
    chk_rx_slvl: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_stat_level |=> irq_status_reg[`ISC_BIT_RX_SLVL])
        else $error("rx status level flag missed");
    chk_rx_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_frame_dropped |=> irq_status_reg[`ISC_BIT_RX_DROP])
        else $error("rx drop flag missed");
    chk_tx_done: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tx_buffer_loaded && notify_on_completion) |=> irq_status_reg[`ISC_BIT_TX_DONE])
        else $error("tx buffer done flag missed");
    chk_tx_halt_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tx_stop_request && tx_halted) |=> irq_status_reg[`ISC_BIT_TX_HALT])
        else $error("tx halt flag missed");

    // negative checks: a half condition must not latch
    chk_tx_plain_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        (tx_buffer_loaded && !notify_on_completion && !irq_status_reg[`ISC_BIT_TX_DONE])
        |=> !irq_status_reg[`ISC_BIT_TX_DONE])
        else $error("tx buffer done flag without notify");
    chk_drop_plain: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!(drop_count_inc && drop_count == `ISC_DROP_HALF_PREV)
         && !irq_status_reg[`ISC_BIT_DROP_HALF]) |=> !irq_status_reg[`ISC_BIT_DROP_HALF])
        else $error("midpoint flag without crossing");
    chk_timer_plain: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!(timer_tick && timer_count == `ISC_TIMER_ZERO)
         && !irq_status_reg[`ISC_BIT_TIMER]) |=> !irq_status_reg[`ISC_BIT_TIMER])
        else $error("timer flag without wrap");

    // no hold-off path exists here; the interval logic sits outside
    chk_power_bypass: assert property (@(posedge core_clk) disable iff (!reset_n)
        power_irq == (irq_status_reg[`ISC_BIT_POWER]
                      && $past(irq_enable_mask[`ISC_BIT_POWER])))
        else $error("power indication held off");
    chk_mask_free: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rx_error && !irq_enable_mask[`ISC_BIT_RX_ERR]) |=> irq_status_reg[`ISC_BIT_RX_ERR])
        else $error("masked flag failed to latch");
    chk_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `ISC_OFS_STATUS && reg_wdata[`ISC_BIT_RX_ERR] && rx_error)
        |=> irq_status_reg[`ISC_BIT_RX_ERR])
        else $error("clear beat a new event");
    chk_phy_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == `ISC_OFS_STATUS && reg_wdata[`ISC_BIT_PHY] && phy_event_pending)
        |=> irq_status_reg[`ISC_BIT_PHY])
        else $error("write cleared the phy flag");
    chk_soft_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (soft_irq_enable && irq_status_reg[`ISC_BIT_SOFT]) |=> irq_status_reg[`ISC_BIT_SOFT])
        else $error("soft flag dropped while enabled");
    chk_wake_only: assert property (@(posedge core_clk) disable iff (!reset_n)
        !(reg_wr && reg_addr == `ISC_OFS_BYTE_TEST) |=> !wake_request)
        else $error("wake without byte test write");

    // reads return a snapshot and never clear anything
    chk_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_rd && reg_addr == `ISC_OFS_STATUS) |=> reg_rdata == $past(irq_status_reg))
        else $error("status read returned wrong word");
    chk_rdata_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        (reg_rd && reg_addr != `ISC_OFS_STATUS) |=> reg_rdata == '0)
        else $error("unmapped read not zero");

    // each pin flag is its own sticky bit
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin_chk
        chk_pin_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
            pin_events[p] |=> irq_status_reg[`ISC_BIT_PIN_LO + p])
            else $error("pin event flag missed");
    end

    // per-bit clear behaviour; the phy bit follows its source instead
    for (genvar b = 0; b < $bits(isc_word_t); b++) begin : g_bit_chk
        if (b != `ISC_BIT_PHY) begin : g_wc
            chk_one_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
                (reg_wr && reg_addr == `ISC_OFS_STATUS && reg_wdata[b] && !set_vec[b])
                |=> !irq_status_reg[b])
                else $error("written one left a flag set");
            chk_zero_keeps: assert property (@(posedge core_clk) disable iff (!reset_n)
                (irq_status_reg[b] && !(reg_wr && reg_addr == `ISC_OFS_STATUS && reg_wdata[b]))
                |=> irq_status_reg[b])
                else $error("flag lost without a clearing write");
        end
    end
endmodule

// ==== isc_host_model.sv ====
// host processor model: single-word register writes and reads
// assumes the collector samples strobes on rising core_clk
`timescale 1ns/1ps
module isc_host_model (
    input  wire logic          core_clk,
    output isc_pkg::isc_addr_t reg_addr,
    output logic               reg_wr,
    output logic               reg_rd,
    output isc_pkg::isc_word_t reg_wdata,
    input  wire logic [31:0]   reg_rdata
);
    import isc_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0;
    end
    // released lines flip so a stale value never looks valid
    task automatic wr(input isc_addr_t a, input isc_word_t d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
        reg_addr = ~a;
    endtask
    task automatic rd(input isc_addr_t a, output isc_word_t q);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        q = reg_rdata;
    endtask
endmodule

// ==== isc_pkg.sv ====
// types for the interrupt status collector
// assumes isc_cfg.svh supplies all numeric constants
package isc_pkg;
    typedef logic [31:0] isc_word_t;
    typedef logic [7:0]  isc_addr_t;
endpackage
